// File: rtl/nic_port_pkg.sv
// Constants, types and register map of the network controller bus master port.
// Assumes one 100 MHz clock that doubles as the bus clock of the DMA cycle.
// Overview of operation
// - Remote write asserts port read strobe in write
// - Host acknowledges latch written after loading word
// - Written acknowledge starts local memory write cycle
// - Attention on receive, transmit, DMA done; maskable
// - Writing interrupt status clears host attention
// - Reset input enters reset mode until start
// - Reset action done within ten bus clocks
// - Bus request raised whenever FIFO needs servicing
// - Arbiter grants with acknowledge, held only while requested
// - Long mode: shared pin strobes upper address
// - Upper strobe floats until bus is granted
// - Short mode: shared pin is port request
// - Shared pin floats until data config written
// - Ready sampled in third state inserts waits
// - Remote read pulses port write strobe, data valid
// - Host acknowledges latch read after taking word
// - Read acknowledge starts next local read cycle
// - Four states per cycle, whole-state wait stretch
// - Address in first state, data after, strobes
package nic_port_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_ISR = 8'h04;
   localparam logic [7:0] OFS_IMR = 8'h08;
   localparam logic [7:0] OFS_DCR = 8'h0C;
   localparam logic [7:0] OFS_TCR = 8'h10;
   localparam logic [7:0] OFS_RSAR_LO = 8'h14;
   localparam logic [7:0] OFS_RSAR_HI = 8'h18;
   localparam logic [7:0] OFS_RADDR = 8'h1C;
   localparam logic [7:0] OFS_RCOUNT = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam int CMD_STOP_BIT = 0;
   localparam int CMD_START_BIT = 1;
   localparam int CMD_RREAD_BIT = 2;
   localparam int CMD_RWRITE_BIT = 3;
   localparam int ISR_RX_BIT = 0;
   localparam int ISR_TX_BIT = 1;
   localparam int ISR_RDC_BIT = 2;
   localparam int ISR_RST_BIT = 3;
   localparam int DCR_LAS_BIT = 0;
   localparam logic [3:0] CMD_RESET = 4'h1;
   localparam logic [3:0] IMR_RESET = 4'h0;
   localparam logic [7:0] DCR_RESET = 8'h00;
   localparam logic [7:0] TCR_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0002;
   localparam int RESET_MAX_CYCLES = 10;
   typedef enum logic [2:0] {PH_IDLE, PH_UA, PH_T1, PH_T2, PH_T3, PH_TW, PH_T4} phase_t;
   typedef enum logic [1:0] {RD_IDLE, RD_CYCLE, RD_WAIT} remote_t;
endpackage

// File: rtl/nic_port_if.sv
// Link between the controller end and the host/arbiter end.
// Assumes the bench drives the memory lane of the shared address/data bus.
`timescale 1ns/1ps
`default_nettype none
interface nic_port_if;
   import nic_port_pkg::*;
   logic [DATA_W-1:0] devAd, hostAd, memAd, adBus;
   logic devAdOe_n, hostAdOe_n, memAdOe_n;
   logic addrStrobe, masterRdStrobe_n, masterWrStrobe_n, masterStrobeOe_n;
   logic portReadStrobe_n, portWriteStrobe_n;
   logic sharedPin, sharedPinOe_n;
   logic latchWrittenAck_n, latchReadAck_n;
   logic busRequest, busGrant, ready, hostAttention, nicReset_n;
   // Bus level from the lane enables
   assign adBus = !devAdOe_n ? devAd : (!hostAdOe_n ? hostAd : (!memAdOe_n ? memAd : '1));
   modport device(input adBus, busGrant, ready, latchWrittenAck_n, latchReadAck_n, nicReset_n,
      output devAd, devAdOe_n, addrStrobe, masterRdStrobe_n, masterWrStrobe_n,
      masterStrobeOe_n, portReadStrobe_n, portWriteStrobe_n, sharedPin, sharedPinOe_n,
      busRequest, hostAttention);
   modport host(input adBus, busRequest, hostAttention, portReadStrobe_n, portWriteStrobe_n,
      sharedPin, sharedPinOe_n,
      output hostAd, hostAdOe_n, busGrant, ready, latchWrittenAck_n, latchReadAck_n,
      nicReset_n);
endinterface
`default_nettype wire

// File: rtl/dma_cycle_seq.sv
// State sequencer of one DMA memory cycle: optional upper address, t1..t4 and waits.
// Assumes start is only pulsed while idle and the bus is granted.
`timescale 1ns/1ps
`default_nettype none
module dma_cycle_seq
   import nic_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic abort,
   input wire logic start,
   input wire logic upperFirst,
   input wire logic ready,
   output nic_port_pkg::phase_t phase,
   output nic_port_pkg::phase_t phaseNext,
   output logic done
);
   import nic_port_pkg::*;
   always_comb begin
      phaseNext = phase;
      case (phase)
         PH_IDLE: if (start) phaseNext = upperFirst ? PH_UA : PH_T1;
         PH_UA: phaseNext = PH_T1;
         PH_T1: phaseNext = PH_T2;
         PH_T2: phaseNext = PH_T3;
         PH_T3: phaseNext = ready ? PH_TW : PH_T4;
         PH_TW: phaseNext = ready ? PH_TW : PH_T4;
         PH_T4: phaseNext = PH_IDLE;
         default: phaseNext = PH_IDLE;
      endcase
      if (abort) phaseNext = PH_IDLE;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) phase <= PH_IDLE;
      else phase <= phaseNext;
   end
   assign done = (phase == PH_T4);
endmodule
`default_nettype wire

// File: rtl/nic_bus_master_port.sv
// Controller end: APB registers, local and remote DMA cycles, latch handshake, attention.
// Assumes APB and link inputs are synchronous to clk; memory sits on the shared bus.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module nic_bus_master_port
   import nic_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fifoReq,
   input wire logic fifoWrite,
   input wire logic [ADDR_W-1:0] fifoAddr,
   input wire logic [DATA_W-1:0] fifoWdata,
   output logic [DATA_W-1:0] fifoRdata,
   output logic fifoAck,
   input wire logic pktRxDone,
   input wire logic pktTxDone,
   output logic netEnable,
   nic_port_if.device link
);
   import nic_port_pkg::*;
   logic [3:0] cmd_q, imr_q, isr_q;
   logic [7:0] dcr_q, tcr_q, rsarLo_q, rsarHi_q;
   logic [ADDR_W-1:0] raddr_q;
   logic [15:0] rcount_q;
   logic dcrWritten_q, cycRemote_q, cycWrite_q, wackSeen_q;
   logic [ADDR_W-1:0] cycAddr_q;
   remote_t rstate_q;
   phase_t phase, phaseNext;
   logic cycDone, hwReset, apbAccess, wrEn, startLocal, startRemote, remoteWant;
   logic [31:0] rdVal;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= OFS_STATUS) && (a[1:0] == 2'b00);
   endfunction

   assign hwReset = !link.nicReset_n;
   assign apbAccess = psel && penable && !pready;
   assign wrEn = psel && penable && pready && pwrite && mapped(paddr);
   assign remoteWant = (rstate_q == RD_IDLE) && (rcount_q != 16'h0000)
      && cmd_q[CMD_RREAD_BIT] && cmd_q[CMD_START_BIT]
      || (rstate_q == RD_WAIT) && cycWrite_q && wackSeen_q;
   assign startRemote = link.busGrant && phase == PH_IDLE && remoteWant;
   assign startLocal = link.busGrant && phase == PH_IDLE && !remoteWant
      && fifoReq && !fifoAck;

   dma_cycle_seq dma_cycle_seq_inst (
      .clk(clk),
      .rst_n(rst_n),
      .abort(hwReset),
      .start(startRemote || startLocal),
      .upperFirst(startRemote && dcr_q[DCR_LAS_BIT]),
      .ready(link.ready),
      .phase(phase),
      .phaseNext(phaseNext),
      .done(cycDone)
   );

   // APB slave: one wait state, error on unmapped word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apbAccess;
         pslverr <= apbAccess && !mapped(paddr);
         prdata <= (apbAccess && !pwrite) ? rdVal : 32'h0000_0000;
      end
   end

   always_comb begin
      rdVal = 32'h0000_0000;
      case (paddr)
         OFS_CMD: rdVal[3:0] = cmd_q;
         OFS_ISR: rdVal[3:0] = isr_q;
         OFS_IMR: rdVal[3:0] = imr_q;
         OFS_DCR: rdVal[7:0] = dcr_q;
         OFS_TCR: rdVal[7:0] = tcr_q;
         OFS_RSAR_LO: rdVal[7:0] = rsarLo_q;
         OFS_RSAR_HI: rdVal[7:0] = rsarHi_q;
         OFS_RADDR: rdVal[15:0] = raddr_q;
         OFS_RCOUNT: rdVal[15:0] = rcount_q;
         OFS_STATUS: rdVal[5:0] = {dcrWritten_q, link.busGrant, rstate_q, phase != PH_IDLE,
            link.busRequest};
         default: rdVal = 32'h0000_0000;
      endcase
   end

   // Control registers; the reset pin acts in the next clock
   always_ff @(posedge clk) begin
      if (!rst_n || hwReset) begin
         cmd_q <= CMD_RESET;
         imr_q <= IMR_RESET;
         dcr_q <= DCR_RESET;
         tcr_q <= TCR_RESET;
      end else if (wrEn) begin
         case (paddr)
            OFS_CMD: cmd_q <= pwdata[3] || pwdata[2] ? pwdata[3:0]
               : {2'b00, pwdata[CMD_START_BIT] && !pwdata[CMD_STOP_BIT],
               !pwdata[CMD_START_BIT] || pwdata[CMD_STOP_BIT]};
            OFS_IMR: imr_q <= pwdata[3:0];
            OFS_DCR: dcr_q <= pwdata[7:0];
            OFS_TCR: tcr_q <= pwdata[7:0];
            default: cmd_q <= cmd_q;
         endcase
      end else if (rstate_q != RD_IDLE && rcount_q == 16'h0000) begin
         cmd_q[CMD_RREAD_BIT] <= 1'b0;
         cmd_q[CMD_RWRITE_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsarLo_q <= 8'h00;
         rsarHi_q <= 8'h00;
         dcrWritten_q <= 1'b0;
      end else if (wrEn) begin
         if (paddr == OFS_RSAR_LO) rsarLo_q <= pwdata[7:0];
         if (paddr == OFS_RSAR_HI) rsarHi_q <= pwdata[7:0];
         if (paddr == OFS_DCR) dcrWritten_q <= 1'b1;
      end
   end

   // Netwide enable only after start; reset mode otherwise
   always_ff @(posedge clk) begin
      if (!rst_n) netEnable <= 1'b0;
      else netEnable <= !hwReset && cmd_q[CMD_START_BIT] && !cmd_q[CMD_STOP_BIT];
   end

   // Sticky status: set wins over write-one-to-clear
   always_ff @(posedge clk) begin
      if (!rst_n) isr_q <= 4'h0;
      else begin
         isr_q <= (wrEn && paddr == OFS_ISR) ? isr_q & ~pwdata[3:0] : isr_q;
         if (pktRxDone && netEnable) isr_q[ISR_RX_BIT] <= 1'b1;
         if (pktTxDone && netEnable) isr_q[ISR_TX_BIT] <= 1'b1;
         if (cycDone && cycRemote_q && rcount_q == 16'h0001) isr_q[ISR_RDC_BIT] <= 1'b1;
         if (hwReset) isr_q[ISR_RST_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) link.hostAttention <= 1'b0;
      else link.hostAttention <= |(isr_q & imr_q);
   end

   // Remote channel: one word through the latch at a time
   always_ff @(posedge clk) begin
      if (!rst_n || hwReset) begin
         rstate_q <= RD_IDLE;
         raddr_q <= 16'h0000;
         rcount_q <= 16'h0000;
         wackSeen_q <= 1'b0;
      end else if (wrEn && paddr == OFS_RADDR) raddr_q <= pwdata[15:0];
      else if (wrEn && paddr == OFS_RCOUNT) rcount_q <= pwdata[15:0];
      else begin
         if (!link.latchWrittenAck_n) wackSeen_q <= 1'b1;
         case (rstate_q)
            RD_IDLE: if (cmd_q[CMD_RWRITE_BIT] && cmd_q[CMD_START_BIT]
               && rcount_q != 16'h0000) rstate_q <= RD_WAIT;
               else if (startRemote) rstate_q <= RD_CYCLE;
            RD_CYCLE: if (cycDone) begin
               raddr_q <= raddr_q + ADDR_STEP;
               rcount_q <= rcount_q - 16'h0001;
               rstate_q <= RD_WAIT;
            end
            RD_WAIT: if (startRemote) begin
               rstate_q <= RD_CYCLE;
               wackSeen_q <= 1'b0;
            end else if (!cycWrite_q && !link.latchReadAck_n) begin
               rstate_q <= RD_IDLE;
            end else if (rcount_q == 16'h0000) rstate_q <= RD_IDLE;
            default: rstate_q <= RD_IDLE;
         endcase
      end
   end

   // Cycle kind captured at start
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cycRemote_q <= 1'b0;
         cycWrite_q <= 1'b0;
         cycAddr_q <= 16'h0000;
      end else if (startRemote || startLocal) begin
         cycRemote_q <= startRemote;
         cycWrite_q <= startRemote ? cmd_q[CMD_RWRITE_BIT] : fifoWrite;
         cycAddr_q <= startRemote ? raddr_q : fifoAddr;
      end else if (rstate_q == RD_IDLE && cmd_q[CMD_RWRITE_BIT]) cycWrite_q <= 1'b1;
   end

   // Bus request held while any cycle is wanted or running
   always_ff @(posedge clk) begin
      if (!rst_n || hwReset) link.busRequest <= 1'b0;
      else link.busRequest <= (fifoReq && !fifoAck) || remoteWant
         || phaseNext != PH_IDLE;
   end

   // Local FIFO answer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fifoAck <= 1'b0;
         fifoRdata <= 16'h0000;
      end else begin
         fifoAck <= cycDone && !cycRemote_q;
         if (phase == PH_T4 && !cycWrite_q) fifoRdata <= link.adBus;
      end
   end

   // Address and strobe pins follow the next cycle state so they line up with it
   always_ff @(posedge clk) begin
      if (!rst_n || hwReset) begin
         link.devAd <= 16'h0000;
         link.devAdOe_n <= 1'b1;
         link.addrStrobe <= 1'b0;
         link.masterRdStrobe_n <= 1'b1;
         link.masterWrStrobe_n <= 1'b1;
         link.masterStrobeOe_n <= 1'b1;
         link.portReadStrobe_n <= 1'b1;
         link.portWriteStrobe_n <= 1'b1;
         link.sharedPin <= 1'b0;
         link.sharedPinOe_n <= 1'b1;
      end else begin
         link.masterStrobeOe_n <= !link.busGrant;
         link.addrStrobe <= phaseNext == PH_T1;
         link.devAdOe_n <= !(phaseNext == PH_UA || phaseNext == PH_T1
            || (phaseNext inside {PH_T2, PH_T3, PH_TW, PH_T4} && cycWrite_q && !cycRemote_q));
         // Address comes straight from the source when T1 follows idle
         link.devAd <= phaseNext == PH_UA ? {rsarHi_q, rsarLo_q}
            : (phaseNext != PH_T1 ? fifoWdata
            : (phase != PH_IDLE ? cycAddr_q : (startRemote ? raddr_q : fifoAddr)));
         link.masterRdStrobe_n <= !(phaseNext inside {PH_T2, PH_T3, PH_TW} && !cycWrite_q);
         link.masterWrStrobe_n <= !(phaseNext inside {PH_T2, PH_T3, PH_TW} && cycWrite_q);
         link.portReadStrobe_n <= !(phaseNext inside {PH_T2, PH_T3, PH_TW, PH_T4}
            && cycWrite_q && cycRemote_q);
         link.portWriteStrobe_n <= !(phaseNext inside {PH_T3, PH_TW}
            && !cycWrite_q && cycRemote_q);
         if (dcr_q[DCR_LAS_BIT]) begin
            link.sharedPin <= phaseNext == PH_UA;
            link.sharedPinOe_n <= !(dcrWritten_q && link.busGrant);
         end else begin
            link.sharedPin <= rstate_q == RD_WAIT;
            link.sharedPinOe_n <= !dcrWritten_q;
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/nic_host_port.sv
// Host end: bus arbiter, external data latch and the latch handshake toward the controller.
// Assumes the user side presents and takes words one at a time.
`timescale 1ns/1ps
`default_nettype none
module nic_host_port
   import nic_port_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic grantEnable,
   input wire logic waitReq,
   input wire logic resetReq,
   input wire logic [DATA_W-1:0] hostWrData,
   input wire logic hostWrValid,
   output logic hostWrTaken,
   output logic [DATA_W-1:0] hostRdData,
   output logic hostRdValid,
   input wire logic hostRdTake,
   output logic attention,
   nic_port_if.host link
);
   import nic_port_pkg::*;
   logic [DATA_W-1:0] latch_q;
   logic pwrPrev_q, latchFull_q;
   // Grant follows request and drops with it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link.busGrant <= 1'b0;
         link.ready <= 1'b0;
         link.nicReset_n <= 1'b1;
         attention <= 1'b0;
      end else begin
         link.busGrant <= link.busRequest && grantEnable;
         link.ready <= waitReq;
         link.nicReset_n <= !resetReq;
         attention <= link.hostAttention;
      end
   end
   // External latch and its acknowledges
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         latch_q <= 16'h0000;
         latchFull_q <= 1'b0;
         pwrPrev_q <= 1'b1;
         link.latchWrittenAck_n <= 1'b1;
         link.latchReadAck_n <= 1'b1;
         hostWrTaken <= 1'b0;
         hostRdValid <= 1'b0;
         hostRdData <= 16'h0000;
      end else begin
         pwrPrev_q <= link.portWriteStrobe_n;
         link.latchWrittenAck_n <= 1'b1;
         link.latchReadAck_n <= 1'b1;
         hostWrTaken <= 1'b0;
         if (!link.portWriteStrobe_n) latch_q <= link.adBus;
         if (link.portWriteStrobe_n && !pwrPrev_q) begin
            hostRdValid <= 1'b1;
            hostRdData <= latch_q;
         end else if (hostRdValid && hostRdTake) begin
            hostRdValid <= 1'b0;
            link.latchReadAck_n <= 1'b0;
         end
         if (hostWrValid && !latchFull_q && link.sharedPin && link.portReadStrobe_n) begin
            latch_q <= hostWrData;
            latchFull_q <= 1'b1;
            hostWrTaken <= 1'b1;
            link.latchWrittenAck_n <= 1'b0;
         end else if (!link.portReadStrobe_n) latchFull_q <= 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link.hostAd <= 16'h0000;
         link.hostAdOe_n <= 1'b1;
      end else begin
         link.hostAd <= latch_q;
         link.hostAdOe_n <= link.portReadStrobe_n;
      end
   end
endmodule
`default_nettype wire

// File: sim/nic_bus_master_port_asserts.sv
// Link checks between the controller end and the host end of the bus master port.
// Assumes link signals and the controller clock and reset come in as plain inputs.
`timescale 1ns/1ps
`default_nettype none
module nic_bus_master_port_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic busRequest,
   input wire logic busGrant,
   input wire logic ready,
   input wire logic addrStrobe,
   input wire logic devAdOe_n,
   input wire logic masterRdStrobe_n,
   input wire logic masterWrStrobe_n,
   input wire logic portReadStrobe_n,
   input wire logic portWriteStrobe_n,
   input wire logic latchWrittenAck_n,
   input wire logic nicReset_n
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   property p_addr_first;
      addrStrobe |-> !devAdOe_n ##1 (!masterRdStrobe_n || !masterWrStrobe_n);
   endproperty
   a_addr_first: assert property (p_addr_first) else $error("no strobe after address");
   property p_t2_t3;
      $fell(masterRdStrobe_n) |=> !masterRdStrobe_n;
   endproperty
   a_t2_t3: assert property (p_t2_t3) else $error("read strobe too short");
   property p_t3_t4;
      $fell(masterRdStrobe_n) ##1 !ready |=> masterRdStrobe_n;
   endproperty
   a_t3_t4: assert property (p_t3_t4) else $error("read strobe too long");
   property p_wait;
      !masterRdStrobe_n && ready |=> !masterRdStrobe_n;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state missing");
   property p_pws_rise;
      $rose(portWriteStrobe_n) |-> $rose(masterRdStrobe_n);
   endproperty
   a_pws_rise: assert property (p_pws_rise) else $error("latch strobe off read cycle");
   property p_prd_write;
      $fell(portReadStrobe_n) |-> $fell(masterWrStrobe_n) && devAdOe_n;
   endproperty
   a_prd_write: assert property (p_prd_write) else $error("latch read off write");
   property p_latch_written_ack_start;
      $fell(latchWrittenAck_n) |-> ##[1:16] $fell(portReadStrobe_n);
   endproperty
   a_latch_written_ack_start: assert property (p_latch_written_ack_start) else $error("no write after ack");
   property p_reset_idle;
      !nicReset_n |=> !busRequest && devAdOe_n && portReadStrobe_n && portWriteStrobe_n;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("pins busy in reset");
   property p_grant_drop;
      $fell(busRequest) |=> !busGrant;
   endproperty
   a_grant_drop: assert property (p_grant_drop) else $error("grant held");
   property p_req_cycle;
      addrStrobe |-> busRequest && busGrant;
   endproperty
   a_req_cycle: assert property (p_req_cycle) else $error("cycle without request");
   c_remote_read: cover property ($rose(portWriteStrobe_n));
   c_remote_write: cover property ($fell(portReadStrobe_n));
   c_wait: cover property (!masterRdStrobe_n && ready);
   c_reset: cover property (!nicReset_n);
endmodule
`default_nettype wire

// File: sim/nic_bus_master_port_test.sv
// Self-checking bench joining the controller end and the host end over the link.
// Assumes the bench models the buffer memory lane and drives APB and user sides.
`timescale 1ns/1ps
`default_nettype none
module nic_bus_master_port_test;
   import nic_port_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pslverr, pready, rsp;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic fifoReq, fifoWrite, fifoAck, pktRxDone, pktTxDone, netEnable, rdHold;
   logic [ADDR_W-1:0] fifoAddr, memAddr;
   logic [DATA_W-1:0] fifoWdata, fifoRdata, hostWrData, hostRdData;
   logic grantEnable, waitReq, resetReq, hostWrValid, hostWrTaken, hostRdValid, hostRdTake;
   logic attention;
   logic [DATA_W-1:0] mem [0:255];
   int mismatches, nTests;
   nic_port_if link();
   nic_bus_master_port nic_bus_master_port_inst(.clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .fifoReq, .fifoWrite, .fifoAddr,
      .fifoWdata, .fifoRdata, .fifoAck, .pktRxDone, .pktTxDone, .netEnable, .link(link));
   nic_host_port nic_host_port_inst(.clk, .rst_n, .grantEnable, .waitReq, .resetReq,
      .hostWrData, .hostWrValid, .hostWrTaken, .hostRdData, .hostRdValid, .hostRdTake,
      .attention, .link(link));
   nic_bus_master_port_asserts nic_bus_master_port_asserts_inst(.clk, .rst_n,
      .busRequest(link.busRequest), .busGrant(link.busGrant), .ready(link.ready),
      .addrStrobe(link.addrStrobe), .devAdOe_n(link.devAdOe_n),
      .masterRdStrobe_n(link.masterRdStrobe_n), .masterWrStrobe_n(link.masterWrStrobe_n),
      .portReadStrobe_n(link.portReadStrobe_n), .portWriteStrobe_n(link.portWriteStrobe_n),
      .latchWrittenAck_n(link.latchWrittenAck_n), .nicReset_n(link.nicReset_n));
   // Buffer memory lane: drives during the read strobe and one state after
   assign link.memAd = mem[memAddr[8:1]];
   assign link.memAdOe_n = link.masterRdStrobe_n && !rdHold;
   always @(posedge clk) begin
      rdHold <= !link.masterRdStrobe_n;
      if (link.addrStrobe === 1'b1) memAddr <= link.adBus;
      if (link.masterWrStrobe_n === 1'b0) mem[memAddr[8:1]] <= link.adBus;
   end
   initial clk = 1'b0;
   always #5 clk = ~clk;
   task automatic complete_run();
      $display("checks %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      rsp = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, r, exp);
   endtask
   task automatic resetRegs();
      rd("cmd", OFS_CMD, 32'h0000_0001);
      rd("imr", OFS_IMR, 32'h0000_0000);
      rd("dcr", OFS_DCR, 32'h0000_0000);
      rd("tcr", OFS_TCR, 32'h0000_0000);
   endtask
   task automatic fifoCycle(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      fifoReq <= 1'b1;
      fifoWrite <= w;
      fifoAddr <= a;
      fifoWdata <= d;
      do @(posedge clk); while (fifoAck !== 1'b1);
      fifoReq <= 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'h1000 + 16'(i);
      {psel, penable, pwrite, fifoReq, fifoWrite, pktRxDone, pktTxDone} <= '0;
      {waitReq, resetReq, hostWrValid, hostRdTake, rst_n} <= '0;
      {paddr, pwdata, fifoAddr, fifoWdata, hostWrData} <= '0;
      grantEnable <= 1'b1;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      resetRegs();
      chk("sharedOe", 32'(link.sharedPinOe_n), 32'h0000_0001);
      rd("unmapped", 8'h30, 32'h0000_0000);
      chk("slverr", 32'(rsp), 32'h0000_0001);
      fifoCycle(1'b1, 16'h0010, 16'hBEEF);
      chk("memWr", 32'(mem[8'h08]), 32'h0000_BEEF);
      cyc(2);
      chk("reqOff", 32'(link.busRequest), 32'h0000_0000);
      grantEnable <= 1'b0;
      fork
         fifoCycle(1'b0, 16'h0012, 16'h0000);
         begin
            cyc(6);
            chk("reqHeld", 32'(link.busRequest), 32'h0000_0001);
            grantEnable <= 1'b1;
         end
      join
      chk("rdData", 32'(fifoRdata), 32'h0000_1009);
      waitReq <= 1'b1;
      fork
         fifoCycle(1'b0, 16'h0030, 16'h0000);
         begin
            cyc(9);
            waitReq <= 1'b0;
         end
      join
      chk("waitData", 32'(fifoRdata), 32'h0000_1018);
      wr(OFS_DCR, 32'h0000_0000);
      cyc(2);
      chk("sharedOn", 32'(link.sharedPinOe_n), 32'h0000_0000);
      wr(OFS_RADDR, 32'h0000_0020);
      wr(OFS_RCOUNT, 32'h0000_0002);
      wr(OFS_CMD, 32'h0000_0006);
      for (int i = 0; i < 2; i++) begin
         do @(posedge clk); while (hostRdValid !== 1'b1);
         cyc(4);
         chk("rdWord", 32'(hostRdData), 32'h0000_1010 + i);
         hostRdTake <= 1'b1;
         @(posedge clk);
         hostRdTake <= 1'b0;
         while (hostRdValid === 1'b1) @(posedge clk);
      end
      rd("isrDone", OFS_ISR, 32'h0000_0004);
      chk("attnMask", 32'(attention), 32'h0000_0000);
      wr(OFS_IMR, 32'h0000_0004);
      cyc(3);
      chk("attnOn", 32'(attention), 32'h0000_0001);
      wr(OFS_ISR, 32'h0000_0004);
      cyc(3);
      chk("attnOff", 32'(attention), 32'h0000_0000);
      rd("isrClr", OFS_ISR, 32'h0000_0000);
      wr(OFS_RADDR, 32'h0000_0040);
      wr(OFS_RCOUNT, 32'h0000_0002);
      wr(OFS_CMD, 32'h0000_000A);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         hostWrData <= 16'hC0D0 + 16'(i);
         hostWrValid <= 1'b1;
         do @(posedge clk); while (hostWrTaken !== 1'b1);
         hostWrValid <= 1'b0;
      end
      do apb(1'b0, OFS_ISR, 32'h0000_0000); while (r[2] !== 1'b1);
      chk("rw0", 32'(mem[8'h20]), 32'h0000_C0D0);
      chk("rw1", 32'(mem[8'h21]), 32'h0000_C0D1);
      wr(OFS_ISR, 32'h0000_000F);
      @(posedge clk);
      {pktRxDone, pktTxDone} <= 2'b11;
      @(posedge clk);
      {pktRxDone, pktTxDone} <= 2'b00;
      rd("isrPkt", OFS_ISR, 32'h0000_0003);
      chk("attnPkt", 32'(attention), 32'h0000_0000);
      wr(OFS_IMR, 32'h0000_0002);
      cyc(3);
      chk("attnTx", 32'(attention), 32'h0000_0001);
      wr(OFS_TCR, 32'h0000_0005);
      wr(OFS_ISR, 32'h0000_000F);
      @(posedge clk);
      resetReq <= 1'b1;
      @(posedge clk);
      resetReq <= 1'b0;
      cyc(10);
      chk("netOff", 32'(netEnable), 32'h0000_0000);
      pktRxDone <= 1'b1;
      @(posedge clk);
      pktRxDone <= 1'b0;
      resetRegs();
      rd("isrRst", OFS_ISR, 32'h0000_0008);
      chk("attnRst", 32'(attention), 32'h0000_0000);
      chk("sharedKeep", 32'(link.sharedPinOe_n), 32'h0000_0000);
      wr(OFS_DCR, 32'h0000_0001);
      wr(OFS_RSAR_LO, 32'h0000_0034);
      wr(OFS_RSAR_HI, 32'h0000_0012);
      chk("upperOff", 32'(link.sharedPinOe_n), 32'h0000_0001);
      wr(OFS_RADDR, 32'h0000_0060);
      wr(OFS_RCOUNT, 32'h0000_0001);
      wr(OFS_CMD, 32'h0000_0006);
      do @(posedge clk); while (link.sharedPin !== 1'b1);
      chk("upperAddr", 32'(link.adBus), 32'h0000_1234);
      chk("upperOn", 32'(link.sharedPinOe_n), 32'h0000_0000);
      do @(posedge clk); while (hostRdValid !== 1'b1);
      chk("longWord", 32'(hostRdData), 32'h0000_1030);
      complete_run();
   end
endmodule
`default_nettype wire
